// *** rtl/spam_pkg.sv ***
package spam_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_CTRL = 8'h98;
  localparam logic [7:0] ADDR_BUF = 8'h99;
  localparam logic [7:0] ADDR_SLAVE = 8'hA9;
  localparam logic [7:0] ADDR_MASK = 8'hB9;

  // Field positions in serial_control_reg
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MPROC = 5;
  localparam int CTL_RXEN = 4;
  localparam int CTL_TX9 = 3;
  localparam int CTL_RX9 = 2;
  localparam int CTL_TXDONE = 1;
  localparam int CTL_RXDONE = 0;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CNT = 4'h0;

  // Machine cycle phases and oversampling
  localparam logic [1:0] PH_C1 = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h2;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h8;

  // Frame lengths and bit indices
  localparam logic [3:0] BITS_M0 = 4'h7;
  localparam logic [3:0] BITS_M1 = 4'hA;
  localparam logic [3:0] BITS_M23 = 4'hB;
  localparam logic [3:0] IDX_START = 4'h0;
  localparam logic [3:0] IDX_NINTH = 4'h9;
  localparam logic [3:0] IDX_STOP_M23 = 4'hA;
  localparam logic [3:0] IDX_SYNC_END = 4'h8;

  // Operating modes
  typedef enum logic [1:0] {
    SPAM_MODE0 = 2'b00,
    SPAM_MODE1 = 2'b01,
    SPAM_MODE2 = 2'b10,
    SPAM_MODE3 = 2'b11
  } spam_mode_t;

  // Transmit and receive sequencer states
  typedef enum logic [1:0] {
    SPAM_IDLE = 2'b00,
    SPAM_ASYNC = 2'b01,
    SPAM_SYNC = 2'b10
  } spam_state_t;

endpackage

// *** rtl/spam_baud.sv ***
`timescale 1ns/10ps
`default_nettype none

module spam_baud #(
  parameter int OVS_W = 4
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic t1_ovf_i,
  input wire logic fixed_rate_i,
  input wire logic half_rate_i,
  output logic [1:0] phase_o,
  output logic c1_o,
  output logic tick_o,
  output logic roll_o
);

  logic [1:0] phase_r;
  logic half_r;
  logic [OVS_W-1:0] div16_r;
  logic src_w;

  // Tick source: machine cycle in mode 2, timer overflow otherwise
  assign c1_o = (phase_r == spam_pkg::PH_C1);
  assign src_w = fixed_rate_i ? c1_o : t1_ovf_i;
  assign tick_o = src_w && (!half_rate_i || half_r);
  assign roll_o = tick_o && (div16_r == {OVS_W{1'b1}});
  assign phase_o = phase_r;

  // Machine cycle phase counter
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Optional halving and the divide-by-16 counter
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_r <= 1'b0;
      div16_r <= '0;
    end else begin
      if (src_w) half_r <= !half_r;
      if (tick_o) div16_r <= div16_r + 1'b1;
    end
  end

endmodule // spam_baud

`default_nettype wire

// *** rtl/spam_addr_match.sv ***
`timescale 1ns/10ps
`default_nettype none

module spam_addr_match (
  input wire logic [7:0] byte_i,
  input wire logic [7:0] slave_address_i,
  input wire logic [7:0] slave_address_mask_i,
  output logic match_o
);

  logic [7:0] bcast_w;
  logic given_hit_w;
  logic bcast_hit_w;

  // Given address: only masked-in bits compare
  assign given_hit_w = ((byte_i ^ slave_address_i) & slave_address_mask_i) == 8'h00;
  // Broadcast address: ones of the OR must match
  assign bcast_w = slave_address_i | slave_address_mask_i;
  assign bcast_hit_w = ((byte_i ^ bcast_w) & bcast_w) == 8'h00;
  assign match_o = given_hit_w || bcast_hit_w;

endmodule // spam_addr_match

`default_nettype wire

// *** rtl/spam_core.sv ***
// Behaviour
// - Shift mode: transmit flag at ninth C1 after write
// - Shift mode receive needs enable, flag clear
// - Shift receive flag set; blocks until cleared
// - Mode 1: start, eight LSB-first, stop
// - Mode 1 stop bit lands in ninth field
// - Mode 1 rate: overflow over 16 or 32
// - Transmit bits aligned to divide-by-16 rollover
// - Mode 1 transmit flag at tenth rollover
// - Non-zero start sample aborts reception
// - Load only if flag clear, gate passes
// - After stop middle, hunt next falling edge
// - Mode 3 equals mode 2 but timer rate
// - Any buffer write starts transmission
// - Async receive starts on start bit, enabled
// - Given address compares masked-in bits only
// - Broadcast is address OR mask, ones compared
// - Address and mask reset to zero
`timescale 1ns/10ps
`default_nettype none

module spam_core (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic t1_ovf_i,
  input wire logic baud_double_i,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o,
  output logic serial_irq_o
);

  // Software state
  logic [7:0] slave_address_r;
  logic [7:0] slave_address_mask_r;
  logic [7:0] serial_buffer_r;
  logic [1:0] mode_r;
  logic multiproc_mode_bit_r;
  logic rx_en_r;
  logic tx9_r;
  logic ninth_rx_bit_r;
  logic tx_done_flag_r;
  logic rx_done_flag_r;
  logic [7:0] rdata_r;

  // Transmit state
  spam_pkg::spam_state_t tx_st_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic tx_out_r;
  logic tx_go_r;
  logic roll_pend_r;

  // Receive state
  spam_pkg::spam_state_t rx_st_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [7:0] rx_data_r;
  logic rx_ninth_r;
  logic rxd_d_r;

  // Baud and phase wires
  logic [1:0] phase_w;
  logic c1_w;
  logic tick_w;
  logic roll_w;
  logic match_w;

  // Register decode
  logic wr_ctrl_w;
  logic wr_buf_w;
  logic wr_slave_w;
  logic wr_mask_w;
  logic [7:0] ctrl_rd_w;
  logic [7:0] rd_mux_w;

  // Sequencer events
  logic async_w;
  logic nine_bit_w;
  logic tx_step_w;
  logic tx_async_end_w;
  logic tx_sync_end_w;
  logic tx_set_w;
  logic rx_edge_w;
  logic rx_sync_go_w;
  logic rx_samp_w;
  logic rx_last_w;
  logic [3:0] rx_last_idx_w;
  logic rx_start_bad_w;
  logic rx_gate_w;
  logic rx_async_load_w;
  logic rx_sync_load_w;
  logic rx_load_w;
  logic rx_set_w;
  logic ninth_load_w;

  // Address decode
  assign wr_ctrl_w = sfr_wr_i && (sfr_addr_i == spam_pkg::ADDR_CTRL);
  assign wr_buf_w = sfr_wr_i && (sfr_addr_i == spam_pkg::ADDR_BUF);
  assign wr_slave_w = sfr_wr_i && (sfr_addr_i == spam_pkg::ADDR_SLAVE);
  assign wr_mask_w = sfr_wr_i && (sfr_addr_i == spam_pkg::ADDR_MASK);

  // Control register image
  assign ctrl_rd_w = {mode_r, multiproc_mode_bit_r, rx_en_r, tx9_r,
                      ninth_rx_bit_r, tx_done_flag_r, rx_done_flag_r};

  // Read mux, unmapped reads give zero
  assign rd_mux_w = (sfr_addr_i == spam_pkg::ADDR_CTRL) ? ctrl_rd_w :
                    (sfr_addr_i == spam_pkg::ADDR_BUF) ? serial_buffer_r :
                    (sfr_addr_i == spam_pkg::ADDR_SLAVE) ? slave_address_r :
                    (sfr_addr_i == spam_pkg::ADDR_MASK) ? slave_address_mask_r :
                    spam_pkg::RST_BYTE;

  // Mode classes
  assign async_w = (mode_r != spam_pkg::SPAM_MODE0);
  assign nine_bit_w = mode_r[1];

  // Rate source: mode 2 fixed, modes 1 and 3 from timer
  spam_baud #(
    .OVS_W(4)
  ) u_baud (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .t1_ovf_i(t1_ovf_i),
    .fixed_rate_i(mode_r == spam_pkg::SPAM_MODE2),
    .half_rate_i(!baud_double_i),
    .phase_o(phase_w),
    .c1_o(c1_w),
    .tick_o(tick_w),
    .roll_o(roll_w)
  );

  // Multiprocessor address filter
  spam_addr_match u_match (
    .byte_i(rx_data_r),
    .slave_address_i(slave_address_r),
    .slave_address_mask_i(slave_address_mask_r),
    .match_o(match_w)
  );

  // Transmit events
  assign tx_step_w = (tx_st_r == spam_pkg::SPAM_ASYNC) && roll_pend_r && c1_w;
  assign tx_async_end_w = tx_step_w && (tx_left_r == 4'h1);
  assign tx_sync_end_w = (tx_st_r == spam_pkg::SPAM_SYNC) && c1_w &&
                         (tx_left_r == spam_pkg::BITS_M0);
  assign tx_set_w = tx_async_end_w || tx_sync_end_w;

  // Receive events
  assign rx_edge_w = (rx_st_r == spam_pkg::SPAM_IDLE) && async_w && rx_en_r &&
                     rxd_d_r && !rxd_i;
  assign rx_sync_go_w = (rx_st_r == spam_pkg::SPAM_IDLE) && !async_w && rx_en_r &&
                        !rx_done_flag_r && (tx_st_r == spam_pkg::SPAM_IDLE) &&
                        c1_w;
  assign rx_samp_w = (rx_st_r == spam_pkg::SPAM_ASYNC) && tick_w &&
                     (rx_cnt_r == spam_pkg::OVS_MID);
  assign rx_last_idx_w = nine_bit_w ? spam_pkg::IDX_STOP_M23 : spam_pkg::IDX_NINTH;
  assign rx_last_w = rx_samp_w && (rx_idx_r == rx_last_idx_w);
  assign rx_start_bad_w = rx_samp_w && (rx_idx_r == spam_pkg::IDX_START) && rxd_i;

  // Acceptance gate
  assign rx_gate_w = !multiproc_mode_bit_r ||
                     (nine_bit_w ? (rx_ninth_r && match_w) : rxd_i);
  assign rx_async_load_w = rx_last_w && !rx_done_flag_r && rx_gate_w;
  assign rx_sync_load_w = (rx_st_r == spam_pkg::SPAM_SYNC) && c1_w &&
                          (rx_idx_r == spam_pkg::IDX_SYNC_END);
  assign rx_load_w = rx_async_load_w || rx_sync_load_w;
  assign rx_set_w = rx_load_w;
  assign ninth_load_w = nine_bit_w ? rx_ninth_r : rxd_i;

  // Pins: shift clock on txd in mode 0, data on rxd
  // Clock held high in the closing phase, so no ninth rising edge
  assign txd_o = ((tx_st_r == spam_pkg::SPAM_SYNC) || (rx_st_r == spam_pkg::SPAM_SYNC)) ?
                 (phase_w[1] || tx_sync_end_w || rx_sync_load_w) : tx_out_r;
  assign rxd_oe_o = (tx_st_r == spam_pkg::SPAM_SYNC);
  assign rxd_o = tx_out_r;
  assign serial_irq_o = tx_done_flag_r || rx_done_flag_r;
  assign sfr_rdata_o = rdata_r;

  // Address registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slave_address_r <= spam_pkg::RST_BYTE;
      slave_address_mask_r <= spam_pkg::RST_BYTE;
    end else begin
      if (wr_slave_w) slave_address_r <= sfr_wdata_i;
      if (wr_mask_w) slave_address_mask_r <= sfr_wdata_i;
    end
  end

  // Control fields written by software
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r <= 2'h0;
      multiproc_mode_bit_r <= 1'b0;
      rx_en_r <= 1'b0;
      tx9_r <= 1'b0;
    end else if (wr_ctrl_w) begin
      mode_r <= sfr_wdata_i[spam_pkg::CTL_MODE_HI:spam_pkg::CTL_MODE_LO];
      multiproc_mode_bit_r <= sfr_wdata_i[spam_pkg::CTL_MPROC];
      rx_en_r <= sfr_wdata_i[spam_pkg::CTL_RXEN];
      tx9_r <= sfr_wdata_i[spam_pkg::CTL_TX9];
    end
  end

  // Flags: hardware set wins over software write
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_done_flag_r <= 1'b0;
      rx_done_flag_r <= 1'b0;
      ninth_rx_bit_r <= 1'b0;
    end else begin
      if (tx_set_w) tx_done_flag_r <= 1'b1;
      else if (wr_ctrl_w) tx_done_flag_r <= sfr_wdata_i[spam_pkg::CTL_TXDONE];
      if (rx_set_w) rx_done_flag_r <= 1'b1;
      else if (wr_ctrl_w) rx_done_flag_r <= sfr_wdata_i[spam_pkg::CTL_RXDONE];
      if (rx_async_load_w) ninth_rx_bit_r <= ninth_load_w;
      else if (wr_ctrl_w) ninth_rx_bit_r <= sfr_wdata_i[spam_pkg::CTL_RX9];
    end
  end

  // Receive buffer and read data
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_buffer_r <= spam_pkg::RST_BYTE;
      rdata_r <= spam_pkg::RST_BYTE;
    end else begin
      if (rx_load_w) serial_buffer_r <= rx_data_r;
      if (sfr_rd_i) rdata_r <= rd_mux_w;
    end
  end

  // Rollover latch, consumed at the next C1; a buffer write drops a stale one
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      roll_pend_r <= 1'b0;
    end else if (roll_w) begin
      roll_pend_r <= 1'b1;
    end else if (c1_w || wr_buf_w) begin
      roll_pend_r <= 1'b0;
    end
  end

  // Transmit sequencer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st_r <= spam_pkg::SPAM_IDLE;
      tx_sh_r <= '1;
      tx_left_r <= spam_pkg::RST_CNT;
      tx_out_r <= 1'b1;
      tx_go_r <= 1'b0;
    end else if (wr_buf_w) begin
      // Any write restarts a frame
      tx_st_r <= async_w ? spam_pkg::SPAM_ASYNC : spam_pkg::SPAM_IDLE;
      tx_go_r <= !async_w;
      tx_left_r <= nine_bit_w ? spam_pkg::BITS_M23 : spam_pkg::BITS_M1;
      tx_sh_r <= {1'b1, (nine_bit_w ? tx9_r : 1'b1), sfr_wdata_i, 1'b0};
    end else begin
      case (tx_st_r)
        spam_pkg::SPAM_IDLE: begin
          if (tx_go_r && c1_w && (rx_st_r == spam_pkg::SPAM_IDLE)) begin
            // First data bit goes out as the clock falls
            tx_st_r <= spam_pkg::SPAM_SYNC;
            tx_go_r <= 1'b0;
            tx_left_r <= spam_pkg::RST_CNT;
            tx_out_r <= tx_sh_r[1];
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
          end
        end
        spam_pkg::SPAM_SYNC: begin
          if (tx_sync_end_w) begin
            tx_st_r <= spam_pkg::SPAM_IDLE;
            tx_out_r <= 1'b1;
          end else if (c1_w) begin
            tx_left_r <= tx_left_r + 4'h1;
            tx_out_r <= tx_sh_r[1];
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
          end
        end
        spam_pkg::SPAM_ASYNC: begin
          if (tx_step_w) begin
            tx_out_r <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_left_r <= tx_left_r - 4'h1;
            if (tx_async_end_w) tx_st_r <= spam_pkg::SPAM_IDLE;
          end
        end
        default: begin
          tx_st_r <= spam_pkg::SPAM_IDLE;
        end
      endcase
    end
  end

  // Previous receive pin level for edge search
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxd_d_r <= 1'b1;
    end else begin
      rxd_d_r <= rxd_i;
    end
  end

  // Receive sequencer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_st_r <= spam_pkg::SPAM_IDLE;
      rx_cnt_r <= spam_pkg::RST_CNT;
      rx_idx_r <= spam_pkg::RST_CNT;
      rx_data_r <= spam_pkg::RST_BYTE;
      rx_ninth_r <= 1'b0;
    end else begin
      case (rx_st_r)
        spam_pkg::SPAM_IDLE: begin
          rx_cnt_r <= spam_pkg::RST_CNT;
          rx_idx_r <= spam_pkg::RST_CNT;
          if (rx_edge_w) begin
            rx_st_r <= spam_pkg::SPAM_ASYNC;
          end else if (rx_sync_go_w) begin
            rx_st_r <= spam_pkg::SPAM_SYNC;
          end
        end
        spam_pkg::SPAM_ASYNC: begin
          if (tick_w) rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_start_bad_w || rx_last_w) begin
            rx_st_r <= spam_pkg::SPAM_IDLE;
          end else if (rx_samp_w) begin
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == spam_pkg::IDX_NINTH) begin
              rx_ninth_r <= rxd_i;
            end else if (rx_idx_r != spam_pkg::IDX_START) begin
              rx_data_r <= {rxd_i, rx_data_r[7:1]};
            end
          end
        end
        spam_pkg::SPAM_SYNC: begin
          if (rx_sync_load_w) begin
            rx_st_r <= spam_pkg::SPAM_IDLE;
          end else if ((phase_w == spam_pkg::PH_RISE) &&
                       (rx_idx_r != spam_pkg::IDX_SYNC_END)) begin
            // Sample on the rising clock; partner moved data on the fall
            rx_data_r <= {rxd_i, rx_data_r[7:1]};
            rx_idx_r <= rx_idx_r + 4'h1;
          end
        end
        default: begin
          rx_st_r <= spam_pkg::SPAM_IDLE;
        end
      endcase
    end
  end

endmodule // spam_core

`default_nettype wire

// *** verif/spam_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

module spam_assertions (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic t1_ovf_i,
  input wire logic baud_double_i,
  input wire logic rxd_i,
  input wire logic rxd_o,
  input wire logic rxd_oe_o,
  input wire logic txd_o,
  input wire logic serial_irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] mode_r;
  logic [7:0] adr_r;
  logic [7:0] msk_r;
  logic wctl_w;
  logic m0_w;
  logic map_w;
  // Decode of bus strobes and current mode
  assign wctl_w = sfr_wr_i && (sfr_addr_i == spam_pkg::ADDR_CTRL);
  assign m0_w = (mode_r[7:6] == 2'b00);
  assign map_w = (sfr_addr_i == spam_pkg::ADDR_CTRL) || (sfr_addr_i == spam_pkg::ADDR_BUF)
    || (sfr_addr_i == spam_pkg::ADDR_SLAVE) || (sfr_addr_i == spam_pkg::ADDR_MASK);
  // Shadow copies of software writes
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r <= 8'h00;
      adr_r <= 8'h00;
      msk_r <= 8'h00;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == spam_pkg::ADDR_CTRL) mode_r <= sfr_wdata_i;
      if (sfr_addr_i == spam_pkg::ADDR_SLAVE) adr_r <= sfr_wdata_i;
      if (sfr_addr_i == spam_pkg::ADDR_MASK) msk_r <= sfr_wdata_i;
    end
  end
  AST_RD_UNMAPPED: assert property (sfr_rd_i && !map_w |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read returned data");
  AST_RD_SLAVE: assert property (
    sfr_rd_i && sfr_addr_i == spam_pkg::ADDR_SLAVE |=> sfr_rdata_o == $past(adr_r))
    else $error("slave address readback wrong");
  AST_RD_MASK: assert property (
    sfr_rd_i && sfr_addr_i == spam_pkg::ADDR_MASK |=> sfr_rdata_o == $past(msk_r))
    else $error("mask readback wrong");
  AST_OE_MODE0: assert property (rxd_oe_o |-> m0_w)
    else $error("data pin driven outside shift mode");
  AST_M0_CLOCK: assert property (
    m0_w && $fell(txd_o) |-> ##[1:2] $rose(txd_o) ##1 txd_o)
    else $error("shift clock phases wrong");
  AST_M0_DATA: assert property (
    m0_w && rxd_oe_o && $past(rxd_oe_o) && $changed(rxd_o) |->
    !txd_o && !$past(txd_o) && $past(txd_o, 2))
    else $error("shift data changed off falling clock");
  AST_M0_DONE: assert property (m0_w && $fell(rxd_oe_o) |-> ##[0:4] serial_irq_o)
    else $error("shift transmit end without flag");
  AST_IRQ_SET: assert property (wctl_w && sfr_wdata_i[1:0] != 2'b00 |=> serial_irq_o)
    else $error("flag write did not raise request");
  AST_IRQ_HOLD: assert property (serial_irq_o && !wctl_w |=> serial_irq_o)
    else $error("request dropped without software clear");
  // Main scenarios reached
  cover property ($rose(serial_irq_o));
  cover property (m0_w && $fell(rxd_oe_o));
  cover property (sfr_rd_i && sfr_addr_i == spam_pkg::ADDR_SLAVE);
endmodule // spam_assertions

bind spam_core spam_assertions i_spam_assertions (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .t1_ovf_i(t1_ovf_i),
  .baud_double_i(baud_double_i), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
  .txd_o(txd_o), .serial_irq_o(serial_irq_o));

`default_nettype wire

// *** verif/spam_peer.sv ***
`timescale 1ns/10ps
`default_nettype none

module spam_peer (
  input wire logic sys_clk_i,
  input wire logic sclk_i,
  output logic line_o
);
  logic [7:0] m0_data = 8'h00;
  logic m0_en = 1'b0;
  logic m0_bit = 1'b1;
  logic [3:0] rises = 4'h0;
  logic aline = 1'b1;
  // Released line follows the framed-send level, which idles high
  assign line_o = m0_en ? m0_bit : aline;
  // Count shift clock rises, present next bit on each fall
  always @(posedge sclk_i) if (m0_en) rises <= rises + 4'h1;
  always @(negedge sclk_i) if (m0_en) m0_bit <= (rises < 4'h8) ? m0_data[rises[2:0]] : 1'b1;
  task automatic m0_load(input logic [7:0] d);
    m0_data = d;
    rises = 4'h0;
    m0_bit = d[0];
    m0_en = 1'b1;
  endtask
  task automatic m0_stop();
    m0_en = 1'b0;
  endtask
  // Framed send: start, data LSB first, stop
  task automatic send(input logic [8:0] d, input int nb, input int p);
    aline <= 1'b0;
    repeat (p) @(negedge sys_clk_i);
    for (int i = 0; i < nb; i++) begin
      aline <= d[i];
      repeat (p) @(negedge sys_clk_i);
    end
    aline <= 1'b1;
    repeat (p) @(negedge sys_clk_i);
  endtask
  // Short low pulse that must not start a frame
  task automatic glitch(input int p);
    aline <= 1'b0;
    repeat (p / 4) @(negedge sys_clk_i);
    aline <= 1'b1;
    repeat (p) @(negedge sys_clk_i);
  endtask
endmodule // spam_peer

`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic t1_ovf_i = 1'b0;
  logic baud_double_i = 1'b1;
  logic [7:0] sfr_rdata_o;
  logic rxd_o;
  logic rxd_oe_o;
  logic txd_o;
  logic serial_irq_o;
  wire logic peer_w;
  wire logic line_w;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int p = 32;
  logic [7:0] cb;
  logic [7:0] ctl;
  logic [7:0] cap = 8'h00;
  // Shared data pin level
  assign line_w = rxd_oe_o ? rxd_o : peer_w;
  always #2 sys_clk_i = ~sys_clk_i;
  // Timer overflow pulse every other cycle
  always @(negedge sys_clk_i) t1_ovf_i <= ~t1_ovf_i;
  // Capture shifted-out data on rising shift clock
  always @(posedge txd_o) if (rxd_oe_o === 1'b1) cap = {line_w, cap[7:1]};
  spam_core i_spam_core (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .t1_ovf_i(t1_ovf_i), .baud_double_i(baud_double_i),
    .rxd_i(line_w), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
    .serial_irq_o(serial_irq_o));
  spam_peer i_spam_peer (.sys_clk_i(sys_clk_i), .sclk_i(txd_o), .line_o(peer_w));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(negedge sys_clk_i);
    sfr_wr_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(negedge sys_clk_i);
    sfr_rd_i <= 1'b0;
    chk(nm, sfr_rdata_o, e);
    @(negedge sys_clk_i);
  endtask
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (serial_irq_o !== 1'b1 && k < lim) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk("irq", {7'h00, serial_irq_o}, 8'h01);
  endtask
  // Peer sends a frame, then control and buffer are read
  task automatic rxf(input logic [8:0] d, input int nb, input logic [7:0] ce, input logic [7:0] be);
    i_spam_peer.send(d, nb, p);
    rd(spam_pkg::ADDR_CTRL, ce, "ctrl");
    rd(spam_pkg::ADDR_BUF, be, "buffer");
  endtask
  // Sample each transmitted bit at its middle
  task automatic txf(input logic [10:0] f, input int nb);
    int k;
    k = 0;
    while (txd_o !== 1'b0 && k < 400) begin
      @(negedge sys_clk_i);
      k++;
    end
    repeat (p / 2) @(negedge sys_clk_i);
    for (int i = 0; i < nb; i++) begin
      chk("txd bit", {7'h00, txd_o}, {7'h00, f[i]});
      if (i < nb - 1) repeat (p) @(negedge sys_clk_i);
    end
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge sys_clk_i);
    rstn_i <= 1'b1;
    @(negedge sys_clk_i);
    rd(spam_pkg::ADDR_SLAVE, 8'h00, "slave");
    rd(spam_pkg::ADDR_MASK, 8'h00, "mask");
    rd(8'h55, 8'h00, "unmapped");
    $display("test reset values done");
    wr(spam_pkg::ADDR_CTRL, 8'h40);
    for (int r = 0; r < 2; r++) begin
      baud_double_i <= (r == 0);
      p = (r == 0) ? 32 : 64;
      cb = (r == 0) ? 8'hA5 : 8'h5C;
      wr(spam_pkg::ADDR_BUF, cb);
      txf({2'b11, cb, 1'b0}, 10);
      rd(spam_pkg::ADDR_CTRL, 8'h42, "ctrl");
      chk("irq", {7'h00, serial_irq_o}, 8'h01);
      wr(spam_pkg::ADDR_CTRL, 8'h40);
    end
    baud_double_i <= 1'b1;
    p = 32;
    wr(spam_pkg::ADDR_CTRL, 8'hC0);
    wr(spam_pkg::ADDR_BUF, 8'h3A);
    txf({2'b10, 8'h3A, 1'b0}, 11);
    rd(spam_pkg::ADDR_CTRL, 8'hC2, "ctrl");
    $display("test async transmit done");
    wr(spam_pkg::ADDR_CTRL, 8'h50);
    rxf(9'h03C, 8, 8'h55, 8'h3C);
    rxf(9'h0C3, 8, 8'h55, 8'h3C);
    wr(spam_pkg::ADDR_CTRL, 8'h40);
    rxf(9'h0EE, 8, 8'h40, 8'h3C);
    wr(spam_pkg::ADDR_CTRL, 8'h50);
    i_spam_peer.glitch(p);
    rxf(9'h081, 8, 8'h55, 8'h81);
    wr(spam_pkg::ADDR_CTRL, 8'h70);
    rxf(9'h05A, 9, 8'h70, 8'h81);
    $display("test async receive done");
    wr(spam_pkg::ADDR_CTRL, 8'hF0);
    rxf(9'h133, 9, 8'hF5, 8'h33);
    wr(spam_pkg::ADDR_SLAVE, 8'hA4);
    wr(spam_pkg::ADDR_MASK, 8'hFA);
    rd(spam_pkg::ADDR_SLAVE, 8'hA4, "slave");
    rd(spam_pkg::ADDR_MASK, 8'hFA, "mask");
    for (int m = 2; m < 4; m++) begin
      p = (m == 2) ? 64 : 32;
      ctl = (m == 2) ? 8'hB0 : 8'hF0;
      wr(spam_pkg::ADDR_CTRL, ctl);
      rxf(9'h1A0, 9, ctl | 8'h05, 8'hA0);
      wr(spam_pkg::ADDR_CTRL, ctl);
      rxf(9'h1A2, 9, ctl, 8'hA0);
      rxf(9'h1FF, 9, ctl | 8'h05, 8'hFF);
      wr(spam_pkg::ADDR_CTRL, ctl);
      rxf(9'h0A0, 9, ctl, 8'hFF);
    end
    $display("test address match done");
    wr(spam_pkg::ADDR_CTRL, 8'h00);
    i_spam_peer.m0_load(8'h6B);
    wr(spam_pkg::ADDR_CTRL, 8'h10);
    wait_irq(200);
    i_spam_peer.m0_stop();
    rd(spam_pkg::ADDR_BUF, 8'h6B, "buffer");
    rd(spam_pkg::ADDR_CTRL, 8'h11, "ctrl");
    wr(spam_pkg::ADDR_CTRL, 8'h00);
    wr(spam_pkg::ADDR_BUF, 8'h96);
    wait_irq(200);
    chk("shifted byte", cap, 8'h96);
    rd(spam_pkg::ADDR_CTRL, 8'h02, "ctrl");
    wr(spam_pkg::ADDR_CTRL, 8'h01);
    chk("irq", {7'h00, serial_irq_o}, 8'h01);
    wr(spam_pkg::ADDR_CTRL, 8'h00);
    chk("irq", {7'h00, serial_irq_o}, 8'h00);
    $display("test shift mode done");
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
